// >>> design/cbp_pkg.sv
// How it works
// - Direct availability high while port accepts cells
// - Drop availability without room, finish current cell
// - Addressed port answers on polled transmit line
// - Poll reply two edges after its address
// - Polled receive line follows complete-cell readiness
// - First byte two edges after enable, flagged
// - Old port releases, new port starts next
`default_nettype none
package cbp_pkg;
    localparam int CBP_PORTS = 4;
    localparam int CBP_PORT_W = 2;
    localparam int CBP_ADDR_W = 5;
    localparam int CBP_DATA_W = 8;
    localparam int CBP_CNT_W = 6;
    localparam logic [CBP_CNT_W-1:0] CBP_CELL_BYTES = 6'h35;
    localparam logic [CBP_CNT_W-1:0] CBP_CNT_ONE = 6'h01;
    localparam logic [CBP_ADDR_W-1:0] CBP_FIRST_ADDR = 5'h00;
    localparam logic [CBP_ADDR_W-1:0] CBP_LAST_ADDR = 5'h03;
    localparam int CBP_FIFO_DEPTH = 32;
    localparam int CBP_FIFO_W = CBP_PORT_W + 1 + CBP_DATA_W;
    // Link clock, two enables, start flag, data and two addresses
    localparam int CBP_SYNC_W = 4 + CBP_DATA_W + 2 * CBP_ADDR_W;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_PRIME,
        RX_SEND
    } cbp_rx_state_t;
endpackage
`default_nettype wire

// >>> design/cbp_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module cbp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = DEPTH[AW:0];
    localparam logic [AW-1:0] PTR_ONE = 1;
    localparam logic [AW:0] COUNT_ONE = 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;

    wire logic push = in_valid & in_ready;
    wire logic pop = out_valid & out_ready;

    assign in_ready = (count != FULL_COUNT);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + PTR_ONE;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + PTR_ONE;
            end
            if (push && !pop) begin
                count <= count + COUNT_ONE;
            end else if (pop && !push) begin
                count <= count - COUNT_ONE;
            end
        end
    end
endmodule
`default_nettype wire

// >>> design/cbp_cell_port.sv
`timescale 1ns/100ps
`default_nettype none
module cbp_cell_port
    import cbp_pkg::*;
(
    // System
    input wire logic CLOCK,
    input wire logic RESET_N,
    // Cell bus clock from the controller
    input wire logic CELL_CLK,
    // Transmit cell bus
    input wire logic [CBP_ADDR_W-1:0] TX_PORT_SELECT,
    input wire logic TX_TRANSFER_ENABLE_N,
    input wire logic TX_START_OF_CELL,
    input wire logic [CBP_DATA_W-1:0] TX_CELL_DATA,
    output logic [CBP_PORTS-1:0] TX_DIRECT_CELL_AVAIL,
    output logic TX_POLLED_CELL_AVAIL,
    // Receive cell bus
    input wire logic [CBP_ADDR_W-1:0] RX_PORT_SELECT,
    input wire logic RX_TRANSFER_ENABLE_N,
    output logic RX_POLLED_CELL_AVAIL,
    output logic [CBP_DATA_W-1:0] RX_CELL_BUS_ALT,
    output logic RX_START_OF_CELL,
    output logic RX_DRIVE_N,
    // Transmit cells towards the line side
    input wire logic [CBP_PORTS-1:0] TX_PORT_ROOM,
    output logic TX_OUT_VALID,
    input wire logic TX_OUT_READY,
    output logic [CBP_DATA_W-1:0] TX_OUT_DATA,
    output logic [CBP_PORT_W-1:0] TX_OUT_PORT,
    output logic TX_OUT_START,
    // Receive cells from the line side
    input wire logic [CBP_PORTS-1:0] RX_CELL_READY,
    output logic RX_PULL,
    output logic [CBP_PORT_W-1:0] RX_PULL_PORT,
    output logic RX_PULL_FIRST,
    input wire logic [CBP_DATA_W-1:0] RX_PULL_DATA
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    // Bus clock and bus pins cross together, so data stays aligned with the edge
    logic [CBP_SYNC_W-1:0] sync1;
    logic [CBP_SYNC_W-1:0] sync2;
    logic link_clk_q;
    wire logic [CBP_SYNC_W-1:0] link_raw;
    wire logic link_clk_s;
    wire logic ten_n_s;
    wire logic tsoc_s;
    wire logic [CBP_DATA_W-1:0] tdata_s;
    wire logic [CBP_ADDR_W-1:0] tx_addr_s;
    wire logic ren_n_s;
    wire logic [CBP_ADDR_W-1:0] rx_addr_s;
    wire logic link_rise;

    assign link_raw = {CELL_CLK, TX_TRANSFER_ENABLE_N, TX_START_OF_CELL, TX_CELL_DATA,
                       TX_PORT_SELECT, RX_TRANSFER_ENABLE_N, RX_PORT_SELECT};
    assign {link_clk_s, ten_n_s, tsoc_s, tdata_s, tx_addr_s, ren_n_s, rx_addr_s} = sync2;
    assign link_rise = link_clk_s & ~link_clk_q;

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            sync1 <= '0;
            sync2 <= '0;
            link_clk_q <= 1'b0;
        end else begin
            sync1 <= link_raw;
            sync2 <= sync1;
            link_clk_q <= link_clk_s;
        end
    end

    // Transmit side
    logic [CBP_ADDR_W-1:0] tx_sel;
    logic tx_sel_ours;
    logic tx_in_cell;
    logic [CBP_CNT_W-1:0] tx_cnt;
    logic tx_wr_valid;
    logic [CBP_FIFO_W-1:0] tx_wr_data;
    logic [CBP_ADDR_W-1:0] tx_poll_q;
    wire logic tx_fifo_in_ready;
    wire logic tx_fifo_out_valid;
    wire logic [CBP_FIFO_W-1:0] tx_fifo_out_data;
    wire logic tx_out_load;
    wire logic tx_take;
    wire logic [CBP_CNT_W-1:0] next_tx_cnt;
    wire logic [CBP_PORTS-1:0] tx_avail_vec;
    wire logic tx_poll_ours;

    assign tx_take = link_rise & ~ten_n_s & tx_sel_ours & (tsoc_s | tx_in_cell);
    assign next_tx_cnt = tsoc_s ? CBP_CNT_ONE : tx_cnt + CBP_CNT_ONE;
    // A full buffer withdraws every port, so the controller stops offering cells
    assign tx_avail_vec = TX_PORT_ROOM & {CBP_PORTS{tx_fifo_in_ready}};
    assign tx_poll_ours = (tx_poll_q <= CBP_LAST_ADDR);
    assign tx_out_load = ~TX_OUT_VALID | TX_OUT_READY;

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            tx_sel <= CBP_FIRST_ADDR;
            tx_sel_ours <= 1'b0;
            tx_in_cell <= 1'b0;
            tx_cnt <= '0;
            tx_poll_q <= CBP_FIRST_ADDR;
            TX_DIRECT_CELL_AVAIL <= '0;
            TX_POLLED_CELL_AVAIL <= 1'b0;
        end else if (link_rise) begin
            if (ten_n_s) begin
                tx_sel <= tx_addr_s;
                tx_sel_ours <= (tx_addr_s <= CBP_LAST_ADDR);
            end
            if (tx_take) begin
                tx_cnt <= next_tx_cnt;
                tx_in_cell <= (next_tx_cnt != CBP_CELL_BYTES);
            end
            tx_poll_q <= tx_addr_s;
            TX_DIRECT_CELL_AVAIL <= tx_avail_vec;
            TX_POLLED_CELL_AVAIL <= tx_poll_ours & tx_avail_vec[tx_poll_q[CBP_PORT_W-1:0]];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            tx_wr_valid <= 1'b0;
            tx_wr_data <= '0;
        end else begin
            tx_wr_valid <= tx_take;
            if (tx_take) begin
                tx_wr_data <= {tx_sel[CBP_PORT_W-1:0], tsoc_s, tdata_s};
            end
        end
    end

    // Bytes offered while the buffer is full are lost; availability guards against it
    cbp_fifo #(.WIDTH(CBP_FIFO_W), .DEPTH(CBP_FIFO_DEPTH)) u_tx_fifo (
        .clock(CLOCK),
        .reset_n(RESET_N),
        .in_valid(tx_wr_valid),
        .in_ready(tx_fifo_in_ready),
        .in_data(tx_wr_data),
        .out_valid(tx_fifo_out_valid),
        .out_ready(tx_out_load),
        .out_data(tx_fifo_out_data)
    );

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            TX_OUT_VALID <= 1'b0;
            TX_OUT_PORT <= '0;
            TX_OUT_START <= 1'b0;
            TX_OUT_DATA <= '0;
        end else if (tx_out_load) begin
            TX_OUT_VALID <= tx_fifo_out_valid;
            {TX_OUT_PORT, TX_OUT_START, TX_OUT_DATA} <= tx_fifo_out_data;
        end
    end

    // Receive side
    cbp_rx_state_t rx_state;
    cbp_rx_state_t next_rx_state;
    logic [CBP_ADDR_W-1:0] rx_sel;
    logic rx_sel_ours;
    logic [CBP_PORT_W-1:0] rx_cell_port;
    logic [CBP_CNT_W-1:0] rx_cnt;
    logic [CBP_DATA_W-1:0] rx_next_byte;
    logic rx_pull_wait;
    logic [CBP_ADDR_W-1:0] rx_poll_q;
    logic rx_drive_first;
    logic rx_drive_next;
    logic rx_release;
    logic rx_pull_req;
    logic rx_pull_first;
    wire logic [CBP_PORT_W-1:0] rx_sel_port;
    wire logic rx_sel_ready;
    wire logic rx_switch;
    wire logic rx_poll_ours;

    assign rx_sel_port = rx_sel[CBP_PORT_W-1:0];
    assign rx_sel_ready = rx_sel_ours & RX_CELL_READY[rx_sel_port];
    assign rx_switch = ~rx_sel_ours | (rx_sel_port != rx_cell_port);
    assign rx_poll_ours = (rx_poll_q <= CBP_LAST_ADDR);

    // Bytes are fetched one bus edge ahead so each is ready when the edge comes
    always_comb begin
        next_rx_state = rx_state;
        rx_drive_first = 1'b0;
        rx_drive_next = 1'b0;
        rx_release = 1'b0;
        rx_pull_req = 1'b0;
        rx_pull_first = 1'b0;
        if (link_rise) begin
            case (rx_state)
                RX_IDLE: begin
                    if (!ren_n_s && rx_sel_ready) begin
                        next_rx_state = RX_PRIME;
                        rx_pull_req = 1'b1;
                        rx_pull_first = 1'b1;
                    end
                end
                RX_PRIME: begin
                    if (ren_n_s) begin
                        next_rx_state = RX_IDLE;
                    end else begin
                        next_rx_state = RX_SEND;
                        rx_drive_first = 1'b1;
                        rx_pull_req = 1'b1;
                    end
                end
                RX_SEND: begin
                    if (!ren_n_s) begin
                        if (rx_switch) begin
                            rx_release = 1'b1;
                            if (rx_sel_ready) begin
                                next_rx_state = RX_PRIME;
                                rx_pull_req = 1'b1;
                                rx_pull_first = 1'b1;
                            end else begin
                                next_rx_state = RX_IDLE;
                            end
                        end else if (rx_cnt == CBP_CELL_BYTES) begin
                            rx_release = 1'b1;
                            next_rx_state = RX_IDLE;
                        end else begin
                            rx_drive_next = 1'b1;
                            rx_pull_req = (rx_cnt != CBP_CELL_BYTES - CBP_CNT_ONE);
                        end
                    end
                end
                default: begin
                    next_rx_state = RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            rx_state <= RX_IDLE;
            rx_sel <= CBP_FIRST_ADDR;
            rx_sel_ours <= 1'b0;
            rx_poll_q <= CBP_FIRST_ADDR;
            RX_POLLED_CELL_AVAIL <= 1'b0;
        end else begin
            rx_state <= next_rx_state;
            if (link_rise) begin
                if (ren_n_s) begin
                    rx_sel <= rx_addr_s;
                    rx_sel_ours <= (rx_addr_s <= CBP_LAST_ADDR);
                end
                rx_poll_q <= rx_addr_s;
                RX_POLLED_CELL_AVAIL <= rx_poll_ours & RX_CELL_READY[rx_poll_q[CBP_PORT_W-1:0]];
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            RX_CELL_BUS_ALT <= '0;
            RX_START_OF_CELL <= 1'b0;
            RX_DRIVE_N <= 1'b1;
            rx_cnt <= '0;
        end else if (rx_drive_first) begin
            RX_CELL_BUS_ALT <= rx_next_byte;
            RX_START_OF_CELL <= 1'b1;
            RX_DRIVE_N <= 1'b0;
            rx_cnt <= CBP_CNT_ONE;
        end else if (rx_drive_next) begin
            RX_CELL_BUS_ALT <= rx_next_byte;
            RX_START_OF_CELL <= 1'b0;
            rx_cnt <= rx_cnt + CBP_CNT_ONE;
        end else if (rx_release) begin
            RX_START_OF_CELL <= 1'b0;
            RX_DRIVE_N <= 1'b1;
        end
    end

    // Line side answers a pull with its byte on the following clock
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            RX_PULL <= 1'b0;
            RX_PULL_PORT <= '0;
            RX_PULL_FIRST <= 1'b0;
            rx_cell_port <= '0;
            rx_pull_wait <= 1'b0;
            rx_next_byte <= '0;
        end else begin
            RX_PULL <= rx_pull_req;
            RX_PULL_FIRST <= rx_pull_first;
            if (rx_pull_req) begin
                RX_PULL_PORT <= rx_pull_first ? rx_sel_port : rx_cell_port;
            end
            if (rx_pull_first) begin
                rx_cell_port <= rx_sel_port;
            end
            rx_pull_wait <= RX_PULL;
            if (rx_pull_wait) begin
                rx_next_byte <= RX_PULL_DATA;
            end
        end
    end

    property p_direct_high;
        (link_rise && TX_PORT_ROOM[0] && tx_fifo_in_ready) |=> TX_DIRECT_CELL_AVAIL[0];
    endproperty
    a_direct_high: assert property (p_direct_high) else $error("direct availability not raised");
    property p_direct_drop;
        (link_rise && (!TX_PORT_ROOM[1] || !tx_fifo_in_ready)) |=> !TX_DIRECT_CELL_AVAIL[1];
    endproperty
    a_direct_drop: assert property (p_direct_drop) else $error("direct availability not dropped");
    property p_tx_poll;
        (link_rise && tx_poll_q == CBP_FIRST_ADDR) |=> TX_POLLED_CELL_AVAIL == $past(tx_avail_vec[0]);
    endproperty
    a_tx_poll: assert property (p_tx_poll) else $error("polled transmit reply wrong");
    property p_poll_foreign;
        (link_rise && tx_poll_q > CBP_LAST_ADDR) |=> !TX_POLLED_CELL_AVAIL;
    endproperty
    a_poll_foreign: assert property (p_poll_foreign) else $error("foreign address answered");
    property p_rx_poll;
        (link_rise && rx_poll_ours && !RX_CELL_READY[rx_poll_q[CBP_PORT_W-1:0]]) |=> !RX_POLLED_CELL_AVAIL;
    endproperty
    a_rx_poll: assert property (p_rx_poll) else $error("polled receive reply wrong");
    property p_first_byte;
        (link_rise && rx_state == RX_PRIME && !ren_n_s)
            |=> RX_START_OF_CELL && !RX_DRIVE_N && RX_CELL_BUS_ALT == $past(rx_next_byte);
    endproperty
    a_first_byte: assert property (p_first_byte) else $error("first byte not flagged");
    property p_flag_once;
        (link_rise && rx_state == RX_SEND && !ren_n_s && RX_START_OF_CELL) |=> !RX_START_OF_CELL;
    endproperty
    a_flag_once: assert property (p_flag_once) else $error("start flag held past first byte");
    property p_changeover;
        (link_rise && rx_state == RX_SEND && !ren_n_s && rx_switch) |=> RX_DRIVE_N && rx_state != RX_SEND;
    endproperty
    a_changeover: assert property (p_changeover) else $error("old port kept driving");
    property p_ignore_foreign;
        (link_rise && !ten_n_s && !tx_sel_ours) |=> !tx_wr_valid;
    endproperty
    a_ignore_foreign: assert property (p_ignore_foreign) else $error("unselected transfer taken");
endmodule
`default_nettype wire

// >>> dv/cbp_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module cbp_ctrl_model
    import cbp_pkg::*;
(
    // Pacing clock
    input wire logic clock,
    // Cell bus towards the ports
    output logic cell_clk,
    output logic [CBP_ADDR_W-1:0] tx_port_select,
    output logic tx_transfer_enable_n,
    output logic tx_start_of_cell,
    output logic [CBP_DATA_W-1:0] tx_cell_data,
    output logic [CBP_ADDR_W-1:0] rx_port_select,
    output logic rx_transfer_enable_n
);
    initial begin
        cell_clk = 1'b0;
        tx_port_select = 5'h1F;
        tx_transfer_enable_n = 1'b1;
        tx_start_of_cell = 1'b0;
        tx_cell_data = 8'h00;
        rx_port_select = 5'h1F;
        rx_transfer_enable_n = 1'b1;
    end

    // One bus clock of 32 system cycles; the clock rests low between calls
    task automatic tick(input logic [CBP_ADDR_W-1:0] ta, input logic ten_n, input logic sof,
                        input logic [CBP_DATA_W-1:0] d, input logic [CBP_ADDR_W-1:0] ra, input logic ren_n);
        tx_port_select <= ta;
        tx_transfer_enable_n <= ten_n;
        tx_start_of_cell <= sof & ~ten_n;
        // Idle data keeps moving so a stale byte can never look valid
        tx_cell_data <= ten_n ? ~tx_cell_data : d;
        rx_port_select <= ra;
        rx_transfer_enable_n <= ren_n;
        repeat (8) @(posedge clock);
        cell_clk <= 1'b1;
        repeat (16) @(posedge clock);
        cell_clk <= 1'b0;
        repeat (8) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// >>> dv/cbp_cell_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
    $display("BAD %0t %s: got %0h expected %0h", $time, msg, got, exp); end end
module cbp_cell_port_tb
    import cbp_pkg::*;
;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic stall = 1'b0;
    logic out_ready = 1'b0;
    logic prev_ren_n = 1'b1;
    logic cell_clk, tx_en_n, tx_sof, rx_en_n, tx_pavail, rx_pavail, rx_soc, rx_drive_n;
    logic out_valid, out_start, pull, pull_first;
    logic [CBP_ADDR_W-1:0] tx_sel, rx_sel, tsel, lpa, lra, pa, ra;
    logic [CBP_DATA_W-1:0] tx_data, rx_bus, out_data, nb;
    logic [CBP_DATA_W-1:0] pull_data = 8'h00;
    logic [CBP_PORTS-1:0] tx_avail;
    logic [CBP_PORTS-1:0] room = 4'hF;
    logic [CBP_PORTS-1:0] cell_ready = 4'h0;
    logic [CBP_PORT_W-1:0] out_port, pull_port;
    logic [CBP_PORT_W-1:0] rx_cur = 2'h0;
    logic [CBP_FIFO_W-1:0] tx_exp;
    logic [CBP_FIFO_W-1:0] txq[$];
    logic [CBP_DATA_W:0] rx_exp;
    logic [CBP_DATA_W:0] rxq[CBP_PORTS][$];
    int fail_count, comparisons, cycles, rx_got, pulls, tcnt, i, p0;

    always #2.5 clock = ~clock;

    cbp_ctrl_model CTRL (.clock(clock), .cell_clk(cell_clk), .tx_port_select(tx_sel),
        .tx_transfer_enable_n(tx_en_n), .tx_start_of_cell(tx_sof), .tx_cell_data(tx_data),
        .rx_port_select(rx_sel), .rx_transfer_enable_n(rx_en_n));

    cbp_cell_port DUT (.CLOCK(clock), .RESET_N(reset_n), .CELL_CLK(cell_clk),
        .TX_PORT_SELECT(tx_sel), .TX_TRANSFER_ENABLE_N(tx_en_n), .TX_START_OF_CELL(tx_sof),
        .TX_CELL_DATA(tx_data), .TX_DIRECT_CELL_AVAIL(tx_avail), .TX_POLLED_CELL_AVAIL(tx_pavail),
        .RX_PORT_SELECT(rx_sel), .RX_TRANSFER_ENABLE_N(rx_en_n), .RX_POLLED_CELL_AVAIL(rx_pavail),
        .RX_CELL_BUS_ALT(rx_bus), .RX_START_OF_CELL(rx_soc), .RX_DRIVE_N(rx_drive_n),
        .TX_PORT_ROOM(room), .TX_OUT_VALID(out_valid), .TX_OUT_READY(out_ready),
        .TX_OUT_DATA(out_data), .TX_OUT_PORT(out_port), .TX_OUT_START(out_start),
        .RX_CELL_READY(cell_ready), .RX_PULL(pull), .RX_PULL_PORT(pull_port),
        .RX_PULL_FIRST(pull_first), .RX_PULL_DATA(pull_data));

    task automatic finish_test();
        $display("Counts: %0d compared, %0d mismatched", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Drives one bus clock and notes every byte the ports must accept
    task automatic tk(input logic [CBP_ADDR_W-1:0] ta, input logic ten_n, input logic sof,
                      input logic [CBP_ADDR_W-1:0] rsel, input logic ren_n);
        logic [CBP_DATA_W-1:0] d;
        d = 8'($urandom);
        if (ten_n) begin
            tsel = ta;
        end else if (tsel <= CBP_LAST_ADDR && (sof || tcnt != 0)) begin
            txq.push_back({tsel[CBP_PORT_W-1:0], sof, d});
            tcnt = sof ? 1 : (tcnt + 1) % int'(CBP_CELL_BYTES);
        end
        CTRL.tick(ta, ten_n, sof, d, rsel, ren_n);
    endtask

    task automatic drain();
        repeat (400) @(posedge clock);
        `CHK(txq.size(), 0, "tx bytes missing")
    endtask

    // Line side: random bytes on pull, ready stalls on request
    always @(posedge clock) begin
        if (pull === 1'b1) begin
            nb = 8'($urandom);
            pull_data <= nb;
            rxq[pull_port].push_back({pull_first, nb});
            pulls++;
        end else begin
            pull_data <= ~pull_data;
        end
        out_ready <= !stall && ($urandom % 4 != 0);
    end

    always @(posedge clock) begin
        if (reset_n && out_valid === 1'b1 && out_ready) begin
            if (txq.size() == 0) begin
                `CHK(1'b1, 1'b0, "extra tx byte")
            end else begin
                tx_exp = txq.pop_front();
                `CHK({out_port, out_start, out_data}, tx_exp, "tx byte")
            end
        end
    end

    // Output seen at a bus edge belongs to the enable of the edge before
    always @(posedge cell_clk) begin
        if (rx_drive_n === 1'b0 && prev_ren_n === 1'b0) begin
            rx_got++;
            if (rxq[rx_cur].size() == 0) begin
                `CHK(1'b1, 1'b0, "extra rx byte")
            end else begin
                rx_exp = rxq[rx_cur].pop_front();
                `CHK({rx_soc, rx_bus}, rx_exp, "rx byte")
            end
        end
        prev_ren_n = rx_en_n;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            $display("BAD %0t timeout", $time);
            finish_test();
        end
    end

    initial begin
        void'($urandom(32'h42B8D91D));
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        repeat (5) @(posedge clock);
        room <= 4'($urandom);
        cell_ready <= 4'($urandom);
        tk(CBP_FIRST_ADDR, 1'b1, 1'b0, CBP_FIRST_ADDR, 1'b1);
        for (i = 0; i < 56; i++) begin
            pa = ($urandom % 5 == 4) ? 5'h1F : 5'($urandom % 4);
            ra = ($urandom % 5 == 4) ? 5'h1F : 5'($urandom % 4);
            tk(pa, 1'b0, i == 0, ra, 1'b1);
            if (i > 0) begin
                `CHK(tx_pavail, (lpa <= CBP_LAST_ADDR) ? room[lpa[1:0]] : 1'b0, "tx poll")
                `CHK(rx_pavail, (lra <= CBP_LAST_ADDR) ? cell_ready[lra[1:0]] : 1'b0, "rx poll")
                `CHK(tx_avail, room, "direct avail")
            end
            lpa = pa;
            lra = ra;
        end
        tk(5'h1F, 1'b1, 1'b0, 5'h1F, 1'b1);
        tk(5'h1F, 1'b0, 1'b1, 5'h1F, 1'b1);
        tk(5'h1F, 1'b0, 1'b0, 5'h1F, 1'b1);
        tk(CBP_LAST_ADDR, 1'b1, 1'b0, 5'h1F, 1'b1);
        tk(CBP_LAST_ADDR, 1'b0, 1'b0, 5'h1F, 1'b1);
        drain();
        $display("Test 1 done: polling and direct availability");
        room <= 4'hF;
        stall <= 1'b1;
        tk(5'h01, 1'b1, 1'b0, 5'h1F, 1'b1);
        for (i = 0; i < 53; i++) begin
            tk(5'h01, 1'b0, i == 0, 5'h1F, 1'b1);
            if (i == 10) room <= 4'hD;
            if (i == 12) `CHK(tx_avail[1], 1'b0, "avail drop")
            if (i == 30) stall <= 1'b0;
        end
        tk(5'h02, 1'b1, 1'b0, 5'h1F, 1'b1);
        for (i = 0; i < 53; i++) tk(5'h02, 1'b0, i == 0, 5'h1F, 1'b1);
        drain();
        $display("Test 2 done: stalled cell and port switch");
        cell_ready <= 4'h5;
        tk(CBP_FIRST_ADDR, 1'b1, 1'b0, 5'h00, 1'b1);
        for (i = 0; i < 54; i++) begin
            tk(CBP_FIRST_ADDR, 1'b1, 1'b0, 5'h00, 1'b0);
            if (i < 2) `CHK({rx_drive_n, rx_soc}, {i == 0, i == 1}, "rx start")
        end
        tk(CBP_FIRST_ADDR, 1'b1, 1'b0, 5'h02, 1'b1);
        rx_cur = 2'h2;
        for (i = 0; i < 54; i++) begin
            tk(CBP_FIRST_ADDR, 1'b1, 1'b0, 5'h02, 1'b0);
            if (i < 2) `CHK({rx_drive_n, rx_soc}, {i == 0, i == 1}, "changeover")
        end
        p0 = pulls;
        tk(CBP_FIRST_ADDR, 1'b1, 1'b0, 5'h1F, 1'b1);
        repeat (3) tk(CBP_FIRST_ADDR, 1'b1, 1'b0, 5'h1F, 1'b0);
        `CHK(pulls, p0, "foreign pull")
        `CHK(rx_drive_n, 1'b1, "rx release")
        `CHK(rx_got, 106, "rx byte count")
        $display("Test 3 done: receive cells and changeover");
        finish_test();
    end
endmodule
`default_nettype wire
